//--- design/clkgen_cfg_pkg.sv
// Package with configuration bit positions, offsets and reset values of the clock generator decode.
package clkgen_cfg_pkg;

   // Configuration image size and register bus shape.
   localparam int CFG_BITS = 128;
   localparam int CFG_BYTES = 16;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int RATIO_W = 6;

   // Register offsets: bytes 0 to 15 hold the image, one status byte follows.
   localparam logic [4:0] CFG_FIRST_OFFSET = 5'h00;
   localparam logic [4:0] CFG_LAST_OFFSET = 5'h0f;
   localparam logic [4:0] STATUS_OFFSET = 5'h10;

   // Status byte fields.
   localparam int STATUS_PD_POS = 0;
   localparam int STATUS_SEL_POS = 1;

   // Reset values.
   localparam logic [127:0] CFG_RESET = 128'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] SYNC_RESET = 3'h0;

   // Power-down enable bit positions.
   localparam int PLL_A_OFF_POS = 21;
   localparam int PLL_B_OFF_POS = 45;
   localparam int PLL_C_OFF_POS = 69;
   localparam int POSTDIV_A_OFF_POS = 120;
   localparam int POSTDIV_B_OFF_POS = 121;
   localparam int POSTDIV_C_OFF_POS = 122;
   localparam int POSTDIV_D_OFF_POS = 123;

   // Reference divider field low bits, each eight bits wide.
   localparam int REF_W = 8;
   localparam int REF_A_LSB = 0;
   localparam int REF_B_LSB = 24;
   localparam int REF_C_FIRST_LSB = 48;
   localparam int REF_C_SECOND_LSB = 72;

   // Feedback divider field low bits, eleven bits: three A-counter, eight M-counter.
   localparam int LOOP_W = 11;
   localparam int ACOUNT_W = 3;
   localparam int MCOUNT_W = 8;
   localparam int LOOP_A_LSB = 8;
   localparam int LOOP_B_LSB = 32;
   localparam int LOOP_C_FIRST_LSB = 56;
   localparam int LOOP_C_SECOND_LSB = 80;

   // Post divider modulus field low bits, four bits each.
   localparam int MOD_W = 4;
   localparam int MOD_A_LSB = 96;
   localparam int MOD_B_LSB = 100;
   localparam int MOD_C_FIRST_LSB = 104;
   localparam int MOD_D_FIRST_LSB = 108;
   localparam int MOD_C_SECOND_LSB = 112;
   localparam int MOD_D_SECOND_LSB = 116;

endpackage

//--- design/clock_gen_power_divider_cfg.sv
// Configuration store and decode for a three-loop clock generator: power-down and divider settings.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps

//Contract
// - Power-down acts only while powerdown input asserted.
// - Loop off enables at bits 21, 45, 69.
// - Post divider A, B off enables bits 120, 121.
// - Reference ratios A, B; C chosen by select.
// - Feedback ratio splits three A, eight M bits.
// - Loop C feedback field chosen by select.
// - Post A, B modulus fixed fields.
// - Select low uses first C, D moduli.
// - Select high uses second C, D moduli.
// - Modulus code maps to sixteen divide ratios.
// - All configuration bits clear at reset.
module clock_gen_power_divider_cfg (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [clkgen_cfg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [clkgen_cfg_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [clkgen_cfg_pkg::DATA_W-1:0] reg_rdata,
   input wire logic powerdown_input,
   input wire logic alt_set_select,
   output logic pll_a_off,
   output logic pll_b_off,
   output logic pll_c_off,
   output logic postdiv_a_off,
   output logic postdiv_b_off,
   output logic postdiv_c_off,
   output logic postdiv_d_off,
   output logic [clkgen_cfg_pkg::REF_W-1:0] ref_ratio_a,
   output logic [clkgen_cfg_pkg::REF_W-1:0] ref_ratio_b,
   output logic [clkgen_cfg_pkg::REF_W-1:0] ref_ratio_c,
   output logic [clkgen_cfg_pkg::ACOUNT_W-1:0] loop_a_acount,
   output logic [clkgen_cfg_pkg::MCOUNT_W-1:0] loop_a_mcount,
   output logic [clkgen_cfg_pkg::ACOUNT_W-1:0] loop_b_acount,
   output logic [clkgen_cfg_pkg::MCOUNT_W-1:0] loop_b_mcount,
   output logic [clkgen_cfg_pkg::ACOUNT_W-1:0] loop_c_acount,
   output logic [clkgen_cfg_pkg::MCOUNT_W-1:0] loop_c_mcount,
   output logic [clkgen_cfg_pkg::RATIO_W-1:0] post_a_ratio,
   output logic [clkgen_cfg_pkg::RATIO_W-1:0] post_b_ratio,
   output logic [clkgen_cfg_pkg::RATIO_W-1:0] post_c_ratio,
   output logic [clkgen_cfg_pkg::RATIO_W-1:0] post_d_ratio
);
   import clkgen_cfg_pkg::*;

   // Whole state of the block in one record.
   typedef struct packed {
      logic [CFG_BITS-1:0] cfg;
      logic [2:0] pd_sync;
      logic [2:0] sel_sync;
      logic pd_level;
      logic sel_level;
      logic [DATA_W-1:0] rdata;
      logic pll_a_off;
      logic pll_b_off;
      logic pll_c_off;
      logic postdiv_a_off;
      logic postdiv_b_off;
      logic postdiv_c_off;
      logic postdiv_d_off;
      logic [REF_W-1:0] ref_a;
      logic [REF_W-1:0] ref_b;
      logic [REF_W-1:0] ref_c;
      logic [LOOP_W-1:0] loop_a;
      logic [LOOP_W-1:0] loop_b;
      logic [LOOP_W-1:0] loop_c;
      logic [RATIO_W-1:0] post_a;
      logic [RATIO_W-1:0] post_b;
      logic [RATIO_W-1:0] post_c;
      logic [RATIO_W-1:0] post_d;
   } state_t;

   state_t cur;
   state_t next_state;

   // Turns a four-bit modulus code into its divide ratio; codes 0 to 15 in ascending order.
   function automatic logic [RATIO_W-1:0] modulus_ratio(input logic [MOD_W-1:0] code);
      logic [RATIO_W-1:0] ratio;
      unique case (code)
         4'h0: ratio = 6'h01;
         4'h1: ratio = 6'h02;
         4'h2: ratio = 6'h03;
         4'h3: ratio = 6'h04;
         4'h4: ratio = 6'h05;
         4'h5: ratio = 6'h06;
         4'h6: ratio = 6'h08;
         4'h7: ratio = 6'h09;
         4'h8: ratio = 6'h0a;
         4'h9: ratio = 6'h0c;
         4'ha: ratio = 6'h0f;
         4'hb: ratio = 6'h10;
         4'hc: ratio = 6'h12;
         4'hd: ratio = 6'h14;
         4'he: ratio = 6'h19;
         4'hf: ratio = 6'h32;
      endcase
      return ratio;
   endfunction

   // Picks one of two fields by the settled select level.
   function automatic logic [LOOP_W-1:0] pick_field(input logic sel, input logic [LOOP_W-1:0] first,
                                                   input logic [LOOP_W-1:0] second);
      return sel ? second : first;
   endfunction

   // Next-state logic: pin synchronisers, register access and decode of the stored image.
   always_comb begin
      next_state = cur;

      // Both pins come from off chip; a change is accepted only once the second and third stages agree.
      next_state.pd_sync = {cur.pd_sync[1:0], powerdown_input};
      next_state.sel_sync = {cur.sel_sync[1:0], alt_set_select};
      if (cur.pd_sync[1] == cur.pd_sync[2]) begin
         next_state.pd_level = cur.pd_sync[2];
      end
      if (cur.sel_sync[1] == cur.sel_sync[2]) begin
         next_state.sel_level = cur.sel_sync[2];
      end

      // Byte writes land straight in the image; reserved bits are stored as written.
      if (reg_wr) begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            if (reg_addr == ADDR_W'(i)) begin
               next_state.cfg[i*DATA_W +: DATA_W] = reg_wdata;
            end
         end
      end

      // Read data is valid only in the cycle after the strobe, zero otherwise and for unmapped offsets.
      next_state.rdata = BYTE_RESET;
      if (reg_rd) begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            if (reg_addr == ADDR_W'(i)) begin
               next_state.rdata = cur.cfg[i*DATA_W +: DATA_W];
            end
         end
         if (reg_addr == STATUS_OFFSET) begin
            next_state.rdata[STATUS_PD_POS] = cur.pd_level;
            next_state.rdata[STATUS_SEL_POS] = cur.sel_level;
         end
      end

      // Off enables only bite while power-down is held; otherwise every section keeps running.
      next_state.pll_a_off = cur.pd_level & cur.cfg[PLL_A_OFF_POS];
      next_state.pll_b_off = cur.pd_level & cur.cfg[PLL_B_OFF_POS];
      next_state.pll_c_off = cur.pd_level & cur.cfg[PLL_C_OFF_POS];
      next_state.postdiv_a_off = cur.pd_level & cur.cfg[POSTDIV_A_OFF_POS];
      next_state.postdiv_b_off = cur.pd_level & cur.cfg[POSTDIV_B_OFF_POS];
      next_state.postdiv_c_off = cur.pd_level & cur.cfg[POSTDIV_C_OFF_POS];
      next_state.postdiv_d_off = cur.pd_level & cur.cfg[POSTDIV_D_OFF_POS];

      // Reference ratios; loop C follows the select pin.
      next_state.ref_a = cur.cfg[REF_A_LSB +: REF_W];
      next_state.ref_b = cur.cfg[REF_B_LSB +: REF_W];
      next_state.ref_c = cur.sel_level ? cur.cfg[REF_C_SECOND_LSB +: REF_W]
                                       : cur.cfg[REF_C_FIRST_LSB +: REF_W];

      // Feedback ratios, later split into A and M counter parts at the ports.
      next_state.loop_a = cur.cfg[LOOP_A_LSB +: LOOP_W];
      next_state.loop_b = cur.cfg[LOOP_B_LSB +: LOOP_W];
      next_state.loop_c = pick_field(cur.sel_level, cur.cfg[LOOP_C_FIRST_LSB +: LOOP_W],
                                     cur.cfg[LOOP_C_SECOND_LSB +: LOOP_W]);

      // Post divider ratios; A and B ignore the select pin, C and D swap whole field sets.
      next_state.post_a = modulus_ratio(cur.cfg[MOD_A_LSB +: MOD_W]);
      next_state.post_b = modulus_ratio(cur.cfg[MOD_B_LSB +: MOD_W]);
      if (cur.sel_level) begin
         next_state.post_c = modulus_ratio(cur.cfg[MOD_C_SECOND_LSB +: MOD_W]);
         next_state.post_d = modulus_ratio(cur.cfg[MOD_D_SECOND_LSB +: MOD_W]);
      end else begin
         next_state.post_c = modulus_ratio(cur.cfg[MOD_C_FIRST_LSB +: MOD_W]);
         next_state.post_d = modulus_ratio(cur.cfg[MOD_D_FIRST_LSB +: MOD_W]);
      end
   end

   // Single state register; reset clears the image so every section comes up on, ratio codes zero.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cur <= '0;
      end else begin
         cur <= next_state;
      end
   end

   // Ports are taken straight from the state flops.
   assign reg_rdata = cur.rdata;
   assign pll_a_off = cur.pll_a_off;
   assign pll_b_off = cur.pll_b_off;
   assign pll_c_off = cur.pll_c_off;
   assign postdiv_a_off = cur.postdiv_a_off;
   assign postdiv_b_off = cur.postdiv_b_off;
   assign postdiv_c_off = cur.postdiv_c_off;
   assign postdiv_d_off = cur.postdiv_d_off;
   assign ref_ratio_a = cur.ref_a;
   assign ref_ratio_b = cur.ref_b;
   assign ref_ratio_c = cur.ref_c;
   // Low three bits count A, upper eight count M.
   assign loop_a_acount = cur.loop_a[ACOUNT_W-1:0];
   assign loop_a_mcount = cur.loop_a[LOOP_W-1:ACOUNT_W];
   assign loop_b_acount = cur.loop_b[ACOUNT_W-1:0];
   assign loop_b_mcount = cur.loop_b[LOOP_W-1:ACOUNT_W];
   assign loop_c_acount = cur.loop_c[ACOUNT_W-1:0];
   assign loop_c_mcount = cur.loop_c[LOOP_W-1:ACOUNT_W];
   assign post_a_ratio = cur.post_a;
   assign post_b_ratio = cur.post_b;
   assign post_c_ratio = cur.post_c;
   assign post_d_ratio = cur.post_d;

endmodule // clock_gen_power_divider_cfg

//--- tb/cfg_sva.sv
// Checker for the configuration decode of the clock generator.
`timescale 1ns/10ps
module cfg_sva (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic powerdown_input,
   input wire logic pll_a_off,
   input wire logic postdiv_a_off,
   input wire logic [7:0] ref_ratio_a,
   input wire logic [2:0] loop_a_acount,
   input wire logic [7:0] loop_a_mcount,
   input wire logic [5:0] post_a_ratio,
   input wire logic [5:0] post_c_ratio
);
   import clkgen_cfg_pkg::*;
   // Divide ratio for each modulus code.
   localparam logic [5:0] DIV_TAB [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a,
      6'h0c, 6'h0f, 6'h10, 6'h12, 6'h14, 6'h19, 6'h32};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // A write not repeated to the same offset at once, so the decode two edges on shows only it.
   sequence lone_wr(logic [4:0] a);
      reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
   endsequence
   a_ref_a_field: assert property (lone_wr(5'h00) |-> ##2 ref_ratio_a == $past(reg_wdata, 3))
      else $error("reference ratio A differs from byte 0");
   a_acount_low: assert property (lone_wr(5'h01) |-> ##2 loop_a_acount == $past(reg_wdata[2:0], 3))
      else $error("A-counter differs from byte 1");
   a_mcount_low: assert property (lone_wr(5'h01) |-> ##2 loop_a_mcount[4:0] == $past(reg_wdata[7:3], 3))
      else $error("M-counter low part differs from byte 1");
   a_mcount_high: assert property (lone_wr(5'h02) |-> ##2 loop_a_mcount[7:5] == $past(reg_wdata[2:0], 3))
      else $error("M-counter high part differs from byte 2");
   a_post_a_decode: assert property (lone_wr(5'h0c) |-> ##2 post_a_ratio == DIV_TAB[$past(reg_wdata[3:0], 3)])
      else $error("post divider A ratio wrong");
   a_post_c_legal: assert property ($past(nrst) |-> post_c_ratio inside {DIV_TAB})
      else $error("post divider C ratio outside the table");
   a_reset_clear: assert property ($rose(nrst) |-> ref_ratio_a == 8'h00 && loop_a_mcount == 8'h00 && !pll_a_off)
      else $error("outputs not cleared by reset");
   a_pd_quiet: assert property (!powerdown_input [*8] |-> !pll_a_off && !postdiv_a_off)
      else $error("section off without power-down");
endmodule // cfg_sva

//--- tb/host_bus.sv
// Host model that programs the configuration bytes over the plain register port.
`timescale 1ns/10ps
module host_bus (
   input wire logic core_clk,
   input wire logic [7:0] reg_rdata,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   // Reserved bit 93 sits in byte 11; the host always sends it clear.
   localparam logic [7:0] RSV_B11 = 8'h20;
   // Idle bus from time zero, so nothing is taken during reset.
   initial begin
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write strobe; a new call waits an edge, so strobes never collide.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= (a == 5'h0b) ? (d & ~RSV_B11) : d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      d = reg_rdata;
   endtask
endmodule // host_bus

//--- tb/tb_top.sv
// Self-checking bench for the clock generator configuration decode.
`timescale 1ns/10ps
module tb_top;
   import clkgen_cfg_pkg::*;
   logic core_clk, nrst, powerdown_input, alt_set_select, reg_wr, reg_rd;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_val, offs;
   logic pll_a_off, pll_b_off, pll_c_off, postdiv_a_off, postdiv_b_off, postdiv_c_off, postdiv_d_off;
   logic [7:0] ref_ratio_a, ref_ratio_b, ref_ratio_c, loop_a_mcount, loop_b_mcount, loop_c_mcount;
   logic [2:0] loop_a_acount, loop_b_acount, loop_c_acount;
   logic [5:0] post_a_ratio, post_b_ratio, post_c_ratio, post_d_ratio;
   int failures = 0;
   int num_checks = 0;
   localparam logic [5:0] DIV_TAB [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a,
      6'h0c, 6'h0f, 6'h10, 6'h12, 6'h14, 6'h19, 6'h32};
   localparam logic [7:0] IMG [12] = '{8'h5a, 8'hab, 8'h06, 8'h33, 8'h1f, 8'h05, 8'h11, 8'h22, 8'h01, 8'h99,
      8'hfe, 8'h02};
   // All seven off outputs in one byte, loop A in bit 6.
   assign offs = {1'b0, pll_a_off, pll_b_off, pll_c_off, postdiv_a_off, postdiv_b_off, postdiv_c_off, postdiv_d_off};
   clock_gen_power_divider_cfg dut_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .powerdown_input(powerdown_input), .alt_set_select(alt_set_select), .pll_a_off(pll_a_off),
      .pll_b_off(pll_b_off), .pll_c_off(pll_c_off), .postdiv_a_off(postdiv_a_off), .postdiv_b_off(postdiv_b_off),
      .postdiv_c_off(postdiv_c_off), .postdiv_d_off(postdiv_d_off), .ref_ratio_a(ref_ratio_a),
      .ref_ratio_b(ref_ratio_b), .ref_ratio_c(ref_ratio_c), .loop_a_acount(loop_a_acount),
      .loop_a_mcount(loop_a_mcount), .loop_b_acount(loop_b_acount), .loop_b_mcount(loop_b_mcount),
      .loop_c_acount(loop_c_acount), .loop_c_mcount(loop_c_mcount), .post_a_ratio(post_a_ratio),
      .post_b_ratio(post_b_ratio), .post_c_ratio(post_c_ratio), .post_d_ratio(post_d_ratio));
   host_bus host_u (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits n edges, then steps past the edge so the design's updates have landed.
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // 250 MHz core clock.
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Pins change only at edges; the pin synchroniser needs about five edges, so eight are allowed.
   initial begin
      nrst = 1'b0;
      powerdown_input = 1'b0;
      alt_set_select = 1'b0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         host_u.rd(5'(i), rd_val);
         check(rd_val, 8'h00);
      end
      check(offs, 8'h00);
      check(8'(post_d_ratio), 8'h01);
      host_u.wr(5'h15, 8'hff);
      host_u.rd(5'h15, rd_val);
      check(rd_val, 8'h00);
      for (int i = 0; i < 12; i++) host_u.wr(5'(i), IMG[i]);
      settle(3);
      check(ref_ratio_a, 8'h5a);
      check(ref_ratio_b, 8'h33);
      check({loop_a_mcount[4:0], loop_a_acount}, 8'hab);
      check(loop_a_mcount, 8'hd5);
      check({loop_b_acount, 5'h00}, 8'he0);
      check(loop_b_mcount, 8'ha3);
      check(ref_ratio_c, 8'h11);
      check({loop_c_acount, loop_c_mcount[4:0]}, 8'h44);
      check(loop_c_mcount, 8'h24);
      // Read back a written byte and the byte that holds the reserved bit, which the host sends clear.
      host_u.rd(5'h09, rd_val);
      check(rd_val, 8'h99);
      host_u.rd(5'h0b, rd_val);
      check(rd_val, 8'h02);
      @(posedge core_clk);
      alt_set_select <= 1'b1;
      settle(8);
      check(ref_ratio_c, 8'h99);
      check({loop_c_acount, loop_c_mcount[4:0]}, 8'hdf);
      check(loop_c_mcount, 8'h5f);
      host_u.rd(5'h10, rd_val);
      check(rd_val, 8'h02);
      // Every modulus code on A, B and the second C, D set.
      for (int c = 0; c < 16; c++) begin
         host_u.wr(5'h0c, {4'(15 - c), 4'(c)});
         host_u.wr(5'h0e, {4'(c), 4'(15 - c)});
         settle(3);
         check(8'(post_a_ratio), 8'(DIV_TAB[c]));
         check(8'(post_b_ratio), 8'(DIV_TAB[15 - c]));
         check(8'(post_c_ratio), 8'(DIV_TAB[15 - c]));
         check(8'(post_d_ratio), 8'(DIV_TAB[c]));
      end
      host_u.wr(5'h0d, 8'h21);
      settle(3);
      check(8'(post_c_ratio), 8'h01);
      // Pins are moved only on a rising edge, never just after one.
      @(posedge core_clk);
      alt_set_select <= 1'b0;
      settle(8);
      check({2'h0, post_c_ratio[2:0], post_d_ratio[2:0]}, 8'h13);
      host_u.wr(5'h02, 8'h26);
      host_u.wr(5'h05, 8'h25);
      host_u.wr(5'h08, 8'h21);
      host_u.wr(5'h0f, 8'h0f);
      settle(8);
      check(offs, 8'h00);
      check(loop_a_mcount, 8'hd5);
      @(posedge core_clk);
      powerdown_input <= 1'b1;
      settle(8);
      check(offs, 8'h7f);
      host_u.rd(5'h10, rd_val);
      check(rd_val, 8'h01);
      host_u.wr(5'h0f, 8'h0e);
      settle(3);
      check(offs, 8'h77);
      @(posedge core_clk);
      powerdown_input <= 1'b0;
      settle(8);
      check(offs, 8'h00);
      report_and_stop();
   end
   // A hang ends the run as a mismatch.
   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      report_and_stop();
   end
endmodule // tb_top
bind clock_gen_power_divider_cfg cfg_sva chk_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .powerdown_input(powerdown_input), .pll_a_off(pll_a_off),
   .postdiv_a_off(postdiv_a_off), .ref_ratio_a(ref_ratio_a), .loop_a_acount(loop_a_acount),
   .loop_a_mcount(loop_a_mcount), .post_a_ratio(post_a_ratio), .post_c_ratio(post_c_ratio));
